// [design/seep_pkg.sv]
// ==========================================================
// shared constants of the serial eeprom instruction port
package seep_pkg;
    // ======================================================
    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int PROG_TIME_MS = 10;
    // longest time, integer division rounds down
    localparam int PROG_CYCLES = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;

    // ======================================================
    // array geometry
    localparam int MEM_WORDS = 16;
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    localparam logic [15:0] LANE_LO = 16'h00ff;
    localparam logic [15:0] LANE_HI = 16'hff00;
    localparam logic [4:0] ADDR_TOP_X8 = 5'h1f;

    // ======================================================
    // opcodes, four bits after the start bit
    localparam logic [1:0] OP2_READ = 2'h2;
    localparam logic [1:0] OP2_WRITE = 2'h1;
    localparam logic [1:0] OP2_ERASE = 2'h3;
    localparam logic [3:0] ERASE_WRITE_ENABLE_CMD = 4'h3;
    localparam logic [3:0] ERASE_WRITE_DISABLE_CMD = 4'h0;
    localparam logic [3:0] ERASE_ALL_CMD = 4'h2;
    localparam logic [3:0] WRITE_ALL_CMD = 4'h1;

    // ======================================================
    // pulse counts from the start bit
    localparam logic [4:0] OPC_LAST = 5'h04;
    localparam logic [4:0] HDR_END_X8 = 5'h09;
    localparam logic [4:0] HDR_END_X16 = 5'h08;
    localparam logic [4:0] FULL_X8 = 5'h12;
    localparam logic [4:0] FULL_X16 = 5'h19;
    localparam logic [4:0] CNT_MAX = 5'h1f;
    localparam logic [3:0] RBITS_X8 = 4'h7;
    localparam logic [3:0] RBITS_X16 = 4'hf;

    typedef enum logic [2:0] {LS_IDLE, LS_HDR, LS_WDATA, LS_RDATA, LS_HOLD} seep_lstate_t;
endpackage : seep_pkg

// [design/seep_prog_timer.sv]
`timescale 1ns/1ps
// ==========================================================
// self-timed programming cycle
module seep_prog_timer
#(
    parameter int CYCLES = seep_pkg::PROG_CYCLES // cycle length in clocks
)
(
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic start, // one-cycle start of a cycle
    output logic busy // high while programming
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES);
    localparam logic [CW-1:0] ONE = CW'(1);

    logic [CW-1:0] cnt_r;

    // runs without any serial clock activity
    always_ff @(posedge clk)
    begin
        if (rst)
            cnt_r <= '0;
        else if (start && cnt_r == '0)
            cnt_r <= LOAD;
        else if (cnt_r != '0)
            cnt_r <= cnt_r - ONE;
    end

    assign busy = (cnt_r != '0);

    a_busy_start: assert property (@(posedge clk) disable iff (rst)
        (start && !busy) |=> busy && cnt_r == LOAD)
        else $error("busy did not start with the full count");
    a_busy_count: assert property (@(posedge clk) disable iff (rst)
        (busy && cnt_r > ONE) |=> busy && cnt_r == $past(cnt_r) - ONE)
        else $error("programming count did not step down");
    a_busy_end: assert property (@(posedge clk) disable iff (rst)
        (cnt_r == ONE) |=> !busy)
        else $error("busy did not end after the last count");
endmodule : seep_prog_timer

// [design/seep_instr_port.sv]
`timescale 1ns/1ps
// ==========================================================
// Summary of operation
// - organisation input high gives 16-bit words, low gives 8-bit bytes.
// - reset clears programming state and leaves erase/write disabled.
// - four opcode bits, then four (x16) or five (x8) address bits.
// - after select rises, first one sampled on rising clock is the start bit.
// - basic variant skips first pulse after select; enhanced treats it as data.
// - opcode 10XX reads 8 or 16 bits from the address.
// - read shifts out one dummy zero, then data msb first.
// - read data out changes only on rising serial clock.
// - select held high streams next address, no dummy zero between words.
// - opcode 01XX with address and data programs the location.
// - single write erases first; cycle runs without serial clock.
// - opcode 11XX sets the location to ones, started by select falling.
// - 0011 enables, 0000 disables erase/write; address ignored.
// - enable holds until disable or reset.
// - opcode 0010 sets all bits to one, started like erase.
// - opcode 0001 writes one word to all addresses without erase.
// - busy drives data out low with select high; ready drives it high.
// - ready shows until a new start bit or select falls.
// - enhanced x8 programming needs exactly 18 pulses from start bit.
// - enhanced x16 needs exactly 25 pulses, for all four programming kinds.
// - sequential read wraps to address zero after the top.
module seep_instr_port
#(
    parameter bit ENHANCED = 1'h0, // 1 treats the first pulse as a data bit
    parameter int PROG_CYCLES = seep_pkg::PROG_CYCLES // programming cycle length
)
(
    input wire logic CLK, // system clock, 20 MHz
    input wire logic RST, // synchronous reset, active high
    input wire logic SCLK, // serial clock from the host
    input wire logic CS, // chip select, active high
    input wire logic DIN, // serial data in
    input wire logic ORG, // organisation, high x16, low x8
    output logic DOUT, // serial data out
    output logic DOUT_OE // high while DOUT is driven
);
    // ======================================================
    // link domain synchronisers
    logic rst_k1_r;
    logic rst_k_r;
    logic org_k1_r;
    logic org_k_r;
    logic busy_k1_r;
    logic busy_k_r;
    logic busy;

    always_ff @(posedge SCLK)
    begin
        rst_k1_r <= RST;
        rst_k_r <= rst_k1_r;
    end

    always_ff @(posedge SCLK)
    begin
        if (rst_k_r)
        begin
            org_k1_r <= 1'h1;
            org_k_r <= 1'h1;
            busy_k1_r <= 1'h0;
            busy_k_r <= 1'h0;
        end
        else
        begin
            org_k1_r <= ORG;
            org_k_r <= org_k1_r;
            busy_k1_r <= busy;
            busy_k_r <= busy_k1_r;
        end
    end

    // ======================================================
    // link domain decode
    seep_pkg::seep_lstate_t lst_r;
    logic dummy_done_r;
    logic q_bit_r;
    logic [15:0] out_r;
    logic [3:0] rcnt_r;
    logic [4:0] cnt_r;
    logic [3:0] opc_r;
    logic [4:0] adr_r;
    logic [15:0] wdata_r;
    logic [4:0] rd_addr_r;
    logic rd_tg_r;
    logic inst_tg_r;
    logic [15:0] rd_data_r;
    logic [4:0] hdr_end;
    logic [4:0] full_cnt;
    logic take_start;
    logic hdr_last;
    logic is_read;
    logic is_wdata;
    logic rd_go;
    logic rd_load;
    logic in_instr;
    logic [4:0] rd_full_addr;
    logic [4:0] rd_next_addr;

    assign hdr_end = org_k_r ? seep_pkg::HDR_END_X16 : seep_pkg::HDR_END_X8;
    assign full_cnt = org_k_r ? seep_pkg::FULL_X16 : seep_pkg::FULL_X8;
    // bus input is ignored while a cycle runs
    assign take_start = (lst_r == seep_pkg::LS_IDLE) && (ENHANCED || dummy_done_r)
        && DIN && !busy_k_r;
    assign hdr_last = (lst_r == seep_pkg::LS_HDR) && (cnt_r == hdr_end);
    assign is_read = (opc_r[3:2] == seep_pkg::OP2_READ);
    assign is_wdata = (opc_r[3:2] == seep_pkg::OP2_WRITE) || (opc_r == seep_pkg::WRITE_ALL_CMD);
    assign rd_go = hdr_last && is_read;
    assign rd_load = (lst_r == seep_pkg::LS_RDATA) && (rcnt_r == 4'h0);
    assign in_instr = (lst_r != seep_pkg::LS_IDLE);
    assign rd_full_addr = org_k_r ? {1'h0, adr_r[2:0], DIN} : {adr_r[3:0], DIN};
    assign rd_next_addr = org_k_r ? {1'h0, rd_addr_r[3:0] + 4'h1}
        : rd_addr_r + 5'h01;

    // frame state; select low clears it without a clock edge
    always_ff @(posedge SCLK or negedge CS)
    begin
        if (!CS)
        begin
            lst_r <= seep_pkg::LS_IDLE;
            dummy_done_r <= 1'h0;
            q_bit_r <= 1'h0;
            out_r <= '0;
            rcnt_r <= 4'h0;
        end
        else if (rst_k_r)
        begin
            lst_r <= seep_pkg::LS_IDLE;
            dummy_done_r <= 1'h0;
            q_bit_r <= 1'h0;
            out_r <= '0;
            rcnt_r <= 4'h0;
        end
        else
        begin
            dummy_done_r <= 1'h1;
            case (lst_r)
                seep_pkg::LS_IDLE:
                begin
                    if (take_start)
                        lst_r <= seep_pkg::LS_HDR;
                end
                seep_pkg::LS_HDR:
                begin
                    if (rd_go)
                    begin
                        lst_r <= seep_pkg::LS_RDATA;
                        q_bit_r <= 1'h0;
                        rcnt_r <= 4'h0;
                    end
                    else if (hdr_last && is_wdata)
                        lst_r <= seep_pkg::LS_WDATA;
                    else if (hdr_last)
                        lst_r <= seep_pkg::LS_HOLD;
                end
                seep_pkg::LS_WDATA:
                begin
                    if (cnt_r == full_cnt - 5'h01)
                        lst_r <= seep_pkg::LS_HOLD;
                end
                seep_pkg::LS_RDATA:
                begin
                    // a word ends straight into the next, no dummy bit
                    if (rcnt_r == 4'h0)
                    begin
                        q_bit_r <= rd_data_r[15];
                        out_r <= {rd_data_r[14:0], 1'h0};
                        rcnt_r <= org_k_r ? seep_pkg::RBITS_X16 : seep_pkg::RBITS_X8;
                    end
                    else
                    begin
                        q_bit_r <= out_r[15];
                        out_r <= {out_r[14:0], 1'h0};
                        rcnt_r <= rcnt_r - 4'h1;
                    end
                end
                seep_pkg::LS_HOLD:
                begin
                    lst_r <= seep_pkg::LS_HOLD;
                end
                default:
                begin
                    lst_r <= seep_pkg::LS_IDLE;
                end
            endcase
        end
    end

    // captured fields outlive the frame so the system side can act on them
    always_ff @(posedge SCLK)
    begin
        if (rst_k_r)
        begin
            cnt_r <= 5'h00;
            opc_r <= 4'h0;
            adr_r <= 5'h00;
            inst_tg_r <= 1'h0;
        end
        else if (take_start)
        begin
            cnt_r <= 5'h01;
            adr_r <= 5'h00;
            inst_tg_r <= ~inst_tg_r;
        end
        else if (in_instr)
        begin
            if (cnt_r != seep_pkg::CNT_MAX)
                cnt_r <= cnt_r + 5'h01;
            if (lst_r == seep_pkg::LS_HDR && cnt_r <= seep_pkg::OPC_LAST)
                opc_r <= {opc_r[2:0], DIN};
            else if (lst_r == seep_pkg::LS_HDR)
                adr_r <= {adr_r[3:0], DIN};
        end
    end

    always_ff @(posedge SCLK)
    begin
        if (rst_k_r)
            wdata_r <= '0;
        else if (CS && lst_r == seep_pkg::LS_WDATA)
            wdata_r <= {wdata_r[14:0], DIN};
    end

    // read request toggle; the address is steady before the toggle lands
    always_ff @(posedge SCLK)
    begin
        if (rst_k_r)
        begin
            rd_addr_r <= 5'h00;
            rd_tg_r <= 1'h0;
        end
        else if (CS && rd_go)
        begin
            rd_addr_r <= rd_full_addr;
            rd_tg_r <= ~rd_tg_r;
        end
        else if (CS && rd_load)
        begin
            rd_addr_r <= rd_next_addr;
            rd_tg_r <= ~rd_tg_r;
        end
    end

    // ======================================================
    // system domain synchronisers
    logic cs1_r;
    logic cs_s_r;
    logic cs_d_r;
    logic it1_r;
    logic it_s_r;
    logic it_seen_r;
    logic rt1_r;
    logic rt_s_r;
    logic rt_seen_r;
    logic org1_r;
    logic org_s_r;

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            cs1_r <= 1'h0;
            cs_s_r <= 1'h0;
            cs_d_r <= 1'h0;
            it1_r <= 1'h0;
            it_s_r <= 1'h0;
            rt1_r <= 1'h0;
            rt_s_r <= 1'h0;
            org1_r <= 1'h1;
            org_s_r <= 1'h1;
        end
        else
        begin
            cs1_r <= CS;
            cs_s_r <= cs1_r;
            cs_d_r <= cs_s_r;
            it1_r <= inst_tg_r;
            it_s_r <= it1_r;
            rt1_r <= rd_tg_r;
            rt_s_r <= rt1_r;
            org1_r <= ORG;
            org_s_r <= org1_r;
        end
    end

    // ======================================================
    // instruction execution at select falling
    logic we_r;
    logic status_r;
    logic [15:0] mem_r [seep_pkg::MEM_WORDS];
    logic exec;
    logic op_erase;
    logic op_write;
    logic op_erase_all_cmd;
    logic op_write_all_cmd;
    logic hdr_ok;
    logic full_ok;
    logic prog_go;
    logic [4:0] x_hdr;
    logic [4:0] x_full;
    logic [3:0] w_idx;
    logic [15:0] lane_mask;
    logic [15:0] wr_pat;
    logic [3:0] r_idx;
    logic [15:0] r_word;

    assign exec = cs_d_r && !cs_s_r && (it_s_r != it_seen_r);
    assign op_erase = (opc_r[3:2] == seep_pkg::OP2_ERASE);
    assign op_write = (opc_r[3:2] == seep_pkg::OP2_WRITE);
    assign op_erase_all_cmd = (opc_r == seep_pkg::ERASE_ALL_CMD);
    assign op_write_all_cmd = (opc_r == seep_pkg::WRITE_ALL_CMD);
    assign x_hdr = org_s_r ? seep_pkg::HDR_END_X16 : seep_pkg::HDR_END_X8;
    assign x_full = org_s_r ? seep_pkg::FULL_X16 : seep_pkg::FULL_X8;
    // an odd pulse count would shift the whole instruction by one bit
    assign hdr_ok = ENHANCED ? (cnt_r == x_full) : (cnt_r > x_hdr);
    assign full_ok = ENHANCED ? (cnt_r == x_full) : (cnt_r >= x_full);
    assign prog_go = exec && we_r && !busy && (((op_erase || op_erase_all_cmd) && hdr_ok)
        || ((op_write || op_write_all_cmd) && full_ok));
    assign w_idx = org_s_r ? adr_r[3:0] : adr_r[4:1];
    assign lane_mask = org_s_r ? seep_pkg::ERASED_WORD
        : (adr_r[0] ? seep_pkg::LANE_HI : seep_pkg::LANE_LO);
    assign wr_pat = org_s_r ? wdata_r : {wdata_r[7:0], wdata_r[7:0]};
    assign r_idx = org_s_r ? rd_addr_r[3:0] : rd_addr_r[4:1];
    assign r_word = mem_r[r_idx];

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            it_seen_r <= 1'h0;
            we_r <= 1'h0;
        end
        else if (exec)
        begin
            it_seen_r <= it_s_r;
            if (cnt_r > x_hdr && opc_r == seep_pkg::ERASE_WRITE_ENABLE_CMD)
                we_r <= 1'h1;
            else if (cnt_r > x_hdr && opc_r == seep_pkg::ERASE_WRITE_DISABLE_CMD)
                we_r <= 1'h0;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < seep_pkg::MEM_WORDS; gi++)
        begin : g_word
            always_ff @(posedge CLK)
            begin
                if (RST)
                    mem_r[gi] <= seep_pkg::ERASED_WORD;
                else if (prog_go && op_erase_all_cmd)
                    mem_r[gi] <= seep_pkg::ERASED_WORD;
                else if (prog_go && op_write_all_cmd)
                    mem_r[gi] <= mem_r[gi] & wr_pat;
                else if (prog_go && op_erase && w_idx == 4'(gi))
                    mem_r[gi] <= mem_r[gi] | lane_mask;
                else if (prog_go && op_write && w_idx == 4'(gi))
                    mem_r[gi] <= (mem_r[gi] & ~lane_mask) | (wr_pat & lane_mask);
            end
        end
    endgenerate

    // byte reads land in the top lane so the msb is always bit 15
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            rt_seen_r <= 1'h0;
            rd_data_r <= '0;
        end
        else if (rt_s_r != rt_seen_r)
        begin
            rt_seen_r <= rt_s_r;
            rd_data_r <= org_s_r ? r_word
                : {(rd_addr_r[0] ? r_word[15:8] : r_word[7:0]), 8'h00};
        end
    end

    seep_prog_timer #(
        .CYCLES(PROG_CYCLES)
    ) u_timer (
        .clk(CLK),
        .rst(RST),
        .start(prog_go),
        .busy(busy)
    );

    // set wins over the clear; only a select fall after ready ends status,
    // so a host that polls by re-raising select still sees ready
    always_ff @(posedge CLK)
    begin
        if (RST)
            status_r <= 1'h0;
        else if (prog_go)
            status_r <= 1'h1;
        else if (!busy && cs_d_r && !cs_s_r)
            status_r <= 1'h0;
    end

    // ======================================================
    // output pin
    assign DOUT = (status_r && !in_instr) ? !busy : q_bit_r;
    assign DOUT_OE = CS;

    // ======================================================
    // checks
    a_org_follow: assert property (@(posedge CLK) disable iff (RST)
        (!$past(RST) && !$past(RST, 2)) |-> org_s_r == $past(ORG, 2))
        else $error("organisation did not follow the pin");
    a_we_reset: assert property (@(posedge CLK) disable iff (RST)
        $fell(RST) |-> !we_r && !status_r && !busy)
        else $error("reset left programming enabled");
    a_no_prog_dis: assert property (@(posedge CLK) disable iff (RST)
        (!we_r && !busy) |=> !busy)
        else $error("programming started while disabled");
    a_busy_low: assert property (@(posedge CLK) disable iff (RST)
        (busy && CS && !in_instr) |-> !DOUT)
        else $error("busy not shown as low");
    a_ready_high: assert property (@(posedge CLK) disable iff (RST)
        (status_r && !busy && CS && !in_instr) |-> DOUT)
        else $error("ready not shown as high");
    a_count_reject: assert property (@(posedge CLK) disable iff (RST)
        (exec && ENHANCED && cnt_r != x_full && !busy) |=> !busy [*2])
        else $error("wrong pulse count still programmed");
    a_start_bit: assert property (@(posedge SCLK) disable iff (rst_k_r || !CS)
        (lst_r == seep_pkg::LS_IDLE && DIN && !busy_k_r && dummy_done_r)
        |=> lst_r == seep_pkg::LS_HDR)
        else $error("start bit not taken");
    a_basic_skip: assert property (@(posedge SCLK) disable iff (rst_k_r || !CS)
        (!ENHANCED && lst_r == seep_pkg::LS_IDLE && !dummy_done_r)
        |=> lst_r == seep_pkg::LS_IDLE)
        else $error("first pulse not skipped");
    a_dummy_zero: assert property (@(posedge SCLK) disable iff (rst_k_r || !CS)
        rd_go |=> lst_r == seep_pkg::LS_RDATA && !q_bit_r ##1 q_bit_r == $past(rd_data_r[15]))
        else $error("read did not begin with a dummy zero");
    a_read_wrap: assert property (@(posedge SCLK) disable iff (rst_k_r || !CS)
        (rd_load && !org_k_r && rd_addr_r == seep_pkg::ADDR_TOP_X8) |=> rd_addr_r == 5'h00)
        else $error("read address did not wrap");
endmodule : seep_instr_port

// [tb/seep_host.sv]
`timescale 1ns/1ps
// ==========================================================
// host end of the three-wire link
module seep_host
(
    output logic sclk, // serial clock, low between pulses; clocks pulses it outside frames
    output logic cs, // chip select
    output logic din, // serial data to the device
    input wire logic dout, // serial data from the device
    output logic [7:0] moved // read bits that moved off the rising edge
);
    localparam int HALF = 500; // keeps the period at or above 1 us
    initial
    begin
        sclk = 1'h0;
        cs = 1'h0;
        din = 1'h0;
        moved = 8'h00;
    end
    // ======================================================
    // one pulse, data set while the clock is low
    task automatic pulse(input logic d, inout logic [31:0] q);
        din = d;
        #HALF sclk = 1'h1;
        #(HALF / 2) q = {q[30:0], dout};
        #(HALF / 2) sclk = 1'h0;
        #(HALF / 2);
        if (cs && dout !== q[0])
            moved = moved + 8'h01;
    endtask : pulse
    task automatic clocks(input int n);
        repeat (n)
        begin
            #HALF sclk = 1'h1;
            #HALF sclk = 1'h0;
        end
    endtask : clocks
    // ======================================================
    // frame: one low lead pulse, then n bits msb first
    task automatic frame(input logic [47:0] bits, input int n, output logic [31:0] q);
        q = 32'h0;
        #300 cs = 1'h1;
        #200;
        pulse(1'h0, q);
        for (int i = n - 1; i >= 0; i--)
            pulse(bits[i], q);
        cs = 1'h0;
        din = ~din;
        #400;
    endtask : frame
    task automatic status(output logic s);
        cs = 1'h1;
        #600 s = dout;
        cs = 1'h0;
        #400;
    endtask : status
endmodule : seep_host

// [tb/serial_eeprom_instruction_port_test.sv]
`timescale 1ns/1ps
module serial_eeprom_instruction_port_test;
    localparam logic [3:0] WR = {seep_pkg::OP2_WRITE, 2'h2};
    localparam logic [3:0] ER = {seep_pkg::OP2_ERASE, 2'h1};
    logic clk, rst, org, sclk, cs, din, dout, dout_oe, s;
    logic [7:0] moved;
    logic [31:0] q;
    int errors = 0;
    int comparisons = 0;
    seep_instr_port #(.ENHANCED(1'h1), .PROG_CYCLES(40)) seep_instr_port_inst (.CLK(clk),
        .RST(rst), .SCLK(sclk), .CS(cs), .DIN(din), .ORG(org), .DOUT(dout), .DOUT_OE(dout_oe));
    seep_host seep_host_inst (.sclk(sclk), .cs(cs), .din(din), .dout(dout), .moved(moved));
    // ======================================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want)
        begin
            errors++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic complete_run;
        if (errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run
    // pad shifts the frame length away from the exact count
    task automatic cmd(input logic [3:0] op, input logic [4:0] a, input logic [15:0] d,
        input int pad);
        logic [47:0] b;
        b = org ? {23'h0, 1'h1, op, a[3:0], d} : {30'h0, 1'h1, op, a, d[7:0]};
        b = pad < 0 ? b >> -pad : b << pad;
        seep_host_inst.frame(b, (org ? 25 : 18) + pad, q);
        #1000;
    endtask : cmd
    task automatic rd(input logic [4:0] a, input int words);
        logic [47:0] b;
        int w;
        w = org ? 16 : 8;
        b = org ? {39'h0, 1'h1, 4'h8, a[3:0]} : {38'h0, 1'h1, 4'h8, a};
        seep_host_inst.frame(b << (w * words), (org ? 9 : 10) + w * words, q);
    endtask : rd
    task automatic prog(input logic [3:0] op, input logic [4:0] a, input logic [15:0] d,
        input int pad, input bit ok);
        cmd(op, a, d, pad);
        if (ok)
        begin
            seep_host_inst.status(s);
            check(s, 0);
            #1000;
            seep_host_inst.status(s);
            check(s, 1);
        end
    endtask : prog
    // ======================================================
    // scenarios
    task automatic s_basic;
        prog(WR, 3, 16'h1234, 0, 0);
        rd(3, 1);
        check(q[16:0], {1'h0, 16'hffff});
        cmd(seep_pkg::ERASE_WRITE_ENABLE_CMD, 5'h1f, 0, 0);
        prog(WR, 3, 16'ha5c3, 0, 1);
        prog(WR, 3, 16'h5a3c, 0, 1);
        rd(3, 1);
        check(q[16:0], {1'h0, 16'h5a3c});
        prog(WR, 15, 16'hbeef, 0, 1);
        prog(WR, 0, 16'h0102, 0, 1);
        rd(15, 2);
        check(q, 32'hbeef0102);
    endtask : s_basic
    task automatic s_count;
        prog(WR, 5, 16'h0, -1, 0);
        prog(WR, 5, 16'h0, 1, 0);
        rd(5, 1);
        check(q[15:0], 16'hffff);
        prog(ER, 3, 16'h0, 0, 1);
        rd(3, 1);
        check(q[15:0], 16'hffff);
    endtask : s_count
    task automatic s_all;
        prog(seep_pkg::ERASE_ALL_CMD, 0, 0, 0, 1);
        rd(0, 1);
        check(q[15:0], 16'hffff);
        prog(seep_pkg::WRITE_ALL_CMD, 0, 16'hf0f3, 0, 1);
        prog(seep_pkg::WRITE_ALL_CMD, 0, 16'h3cff, 0, 1);
        rd(9, 1);
        check(q[15:0], 16'h30f3);
    endtask : s_all
    task automatic s_bytes;
        @(negedge clk) org = 1'h0;
        prog(WR, 6, 16'h11, 1, 0);
        prog(WR, 6, 16'h5e, 0, 1);
        rd(6, 2);
        check(q[15:0], 16'h5e30);
        rd(31, 2);
        check(q[15:0], 16'h30f3);
        @(negedge clk) org = 1'h1;
        cmd(seep_pkg::ERASE_WRITE_DISABLE_CMD, 0, 0, 0);
        prog(WR, 2, 16'h0, 0, 0);
        rd(2, 1);
        check(q[15:0], 16'h30f3);
    endtask : s_bytes
    // ======================================================
    // clock, reset and main sequence
    initial
    begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    initial
    begin
        #4ms;
        errors++;
        complete_run();
    end
    initial
    begin
        rst = 1'h1;
        org = 1'h1;
        repeat (3) @(negedge clk);
        seep_host_inst.clocks(3);
        @(negedge clk) rst = 1'h0;
        seep_host_inst.clocks(3);
        s_basic();
        s_count();
        s_all();
        s_bytes();
        check(moved, 0);
        check(dout_oe, 0);
        complete_run();
    end
endmodule : serial_eeprom_instruction_port_test
